// File: design/ocsp_pkg.sv
package ocsp_pkg;

  localparam int NUM_CH   = 8;
  localparam int CH_W     = 3;
  localparam int RES_W    = 18;
  localparam int PKT_W    = 24;
  localparam int RANGE_W  = 24;
  localparam int POS_W    = 5;
  localparam int LAST_BIT = PKT_W - 1;

  // every channel in range code 7 after reset
  localparam logic [RANGE_W-1:0] RANGE_RESET = 24'hffffff;
  localparam logic [CH_W-1:0]    RANGE_OFF   = 3'h0;

  // timing, clock period and per-channel conversion time in ns
  localparam int CLK_NS         = 20;
  localparam int CONV_NS_PER_CH = 550;
  localparam int CYC_PER_CH     = CONV_NS_PER_CH / CLK_NS;
  localparam int POWERUP_MS     = 10;
  localparam int INIT_WAIT_CYC  = POWERUP_MS * 1000000 / CLK_NS;
  localparam int CONV_CNT_W     = 8;
  localparam int MIN_CONV_CYC   = 2;
  localparam int LOAD_PKT_AT    = 2;
  localparam int LOAD_LANE_AT   = 1;

  typedef struct packed {
    logic [RES_W-1:0] result;
    logic [CH_W-1:0]  chan;
    logic [CH_W-1:0]  range;
  } ocsp_packet_type;

  typedef struct packed {
    logic sck;
    logic config_serial_in;
    logic cs_n;
    logic convert_strobe;
  } ocsp_pins_type;

  localparam ocsp_pins_type PINS_IDLE = '{sck: 1'b0, config_serial_in: 1'b0, cs_n: 1'b1, convert_strobe: 1'b0};

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } ocsp_state_type;

endpackage

// File: design/ocsp_lane.sv
`timescale 1ns/1ps
`default_nettype none

// one serial result lane: starts at its own channel and walks the
// packet ring upward, one bit per advance
module ocsp_lane
  import ocsp_pkg::*;
#(
  parameter int LANE = 0
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          ce_i,
  input  wire logic                          load_i,
  input  wire logic                          adv_i,
  input  wire ocsp_packet_type [NUM_CH-1:0]  pkts_i,
  output logic                               bit_o
);

  localparam logic [CH_W-1:0] OWN_CH = CH_W'(LANE);

  logic             out_r;
  logic [CH_W-1:0]  nch_r;
  logic [POS_W-1:0] npos_r;
  logic             first_bit;

  assign first_bit = pkts_i[OWN_CH][LAST_BIT];
  assign bit_o     = out_r;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      out_r  <= 1'b0;
      nch_r  <= OWN_CH;
      npos_r <= POS_W'(LAST_BIT);
    end else if (ce_i) begin
      if (load_i) begin
        out_r  <= first_bit;
        nch_r  <= OWN_CH;
        npos_r <= POS_W'(LAST_BIT - 1);
      end else if (adv_i) begin
        out_r <= pkts_i[nch_r][npos_r];
        if (npos_r == '0) begin
          npos_r <= POS_W'(LAST_BIT);
          nch_r  <= nch_r + 3'h1;
        end else begin
          npos_r <= npos_r - 5'h1;
        end
      end
    end
  end

  a_lane_first_bit: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    load_i |=> (out_r == $past(first_bit)) && (nch_r == OWN_CH))
    else $error("lane did not load its own channel msb");

  a_lane_ring_wrap: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (adv_i && !load_i && npos_r == '0) |=> (npos_r == POS_W'(LAST_BIT)) && (nch_r == $past(nch_r) + 3'h1))
    else $error("lane did not wrap to the next channel");

endmodule

`default_nettype wire

// File: design/ocsp_port.sv
`timescale 1ns/1ps
`default_nettype none

module ocsp_port
  import ocsp_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_WAIT_CYC
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          ce_i,
  input  wire logic                          serial_clock_in_i,
  input  wire logic                          config_serial_in_i,
  input  wire logic                          chip_select_n_i,
  input  wire logic                          convert_strobe_i,
  input  wire logic [NUM_CH-1:0][RES_W-1:0]  sample_data_i,
  output logic      [NUM_CH-1:0]             result_lanes_o,
  output logic      [NUM_CH-1:0]             result_lanes_oe_n_o,
  output logic                               echo_clock_out_o,
  output logic                               echo_clock_out_oe_n_o,
  output logic                               busy_o,
  output logic                               window_open_o,
  output logic      [RANGE_W-1:0]            range_o
);

  localparam int INIT_W = $clog2(INIT_CYCLES + 1);
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

  ocsp_pins_type                pin_in;
  ocsp_pins_type                s1_r;
  ocsp_pins_type                s2_r;
  ocsp_pins_type                s3_r;
  logic                         sck_rise;
  logic                         cnv_rise;
  logic                         adv;

  ocsp_state_type               state_r;
  logic                         busy_r;
  logic                         window_r;
  logic [INIT_W-1:0]            init_cnt_r;
  logic [CONV_CNT_W-1:0]        conv_cnt_r;
  logic [CONV_CNT_W-1:0]        conv_len_nxt;
  logic [3:0]                   n_enabled;
  logic                         open_evt;
  logic                         pkt_load;
  logic                         lane_load;

  logic [NUM_CH-1:0][RES_W-1:0] samp_r;
  logic [RANGE_W-1:0]           conv_range_r;
  ocsp_packet_type [NUM_CH-1:0] pkt_r;

  logic [RANGE_W-1:0]           range_r;
  logic [RANGE_W-1:0]           shift_r;
  logic [POS_W-1:0]             bit_cnt_r;
  logic [RANGE_W-1:0]           word_nxt;
  logic                         word_done;

  logic                         echo_r;
  logic [NUM_CH-1:0]            lane_bits;

  // all pins cross into the reference clock domain through two flops
  assign pin_in = '{sck: serial_clock_in_i, config_serial_in: config_serial_in_i,
                    cs_n: chip_select_n_i, convert_strobe: convert_strobe_i};

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s1_r <= PINS_IDLE;
      s2_r <= PINS_IDLE;
      s3_r <= PINS_IDLE;
    end else if (ce_i) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // edge found from the level change, so either idle level works
  assign sck_rise = s2_r.sck & ~s3_r.sck;
  assign cnv_rise = s2_r.convert_strobe & ~s3_r.convert_strobe;
  // shifting is not gated by busy: late reads still work, at a cost in accuracy
  assign adv      = sck_rise & ~s2_r.cs_n;

  always_comb begin
    n_enabled = 4'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (range_r[i*CH_W +: CH_W] != RANGE_OFF) begin
        n_enabled = n_enabled + 4'h1;
      end
    end
  end

  always_comb begin
    conv_len_nxt = CONV_CNT_W'(n_enabled * CYC_PER_CH);
    if (conv_len_nxt < CONV_CNT_W'(MIN_CONV_CYC)) begin
      conv_len_nxt = CONV_CNT_W'(MIN_CONV_CYC);
    end
  end

  assign pkt_load  = (state_r == ST_CONV) && (conv_cnt_r == CONV_CNT_W'(LOAD_PKT_AT));
  assign lane_load = (state_r == ST_CONV) && (conv_cnt_r == CONV_CNT_W'(LOAD_LANE_AT));
  assign open_evt  = lane_load || ((state_r == ST_INIT) && (init_cnt_r == INIT_LAST));

  // conversion sequencer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_r    <= ST_INIT;
      busy_r     <= 1'b0;
      window_r   <= 1'b0;
      init_cnt_r <= '0;
      conv_cnt_r <= '0;
    end else if (ce_i) begin
      case (state_r)
        ST_INIT: begin
          if (init_cnt_r == INIT_LAST) begin
            state_r  <= ST_IDLE;
            window_r <= 1'b1;
          end else begin
            init_cnt_r <= init_cnt_r + INIT_W'(1);
          end
        end
        ST_IDLE: begin
          if (cnv_rise) begin
            state_r    <= ST_CONV;
            busy_r     <= 1'b1;
            window_r   <= 1'b0;
            conv_cnt_r <= conv_len_nxt;
          end
        end
        ST_CONV: begin
          if (lane_load) begin
            state_r  <= ST_IDLE;
            busy_r   <= 1'b0;
            window_r <= 1'b1;
          end else begin
            conv_cnt_r <= conv_cnt_r - 8'h1;
          end
        end
        default: begin
          state_r <= ST_INIT;
        end
      endcase
    end
  end

  // simultaneous sample of all channels, with the range in force
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      samp_r       <= '0;
      conv_range_r <= RANGE_RESET;
    end else if (ce_i && state_r == ST_IDLE && cnv_rise) begin
      samp_r       <= sample_data_i;
      conv_range_r <= range_r;
    end
  end

  // result packets; a disabled channel reports a zero result
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pkt_r <= '0;
    end else if (ce_i && pkt_load) begin
      for (int i = 0; i < NUM_CH; i++) begin
        pkt_r[i].chan  <= CH_W'(i);
        pkt_r[i].range <= conv_range_r[i*CH_W +: CH_W];
        if (conv_range_r[i*CH_W +: CH_W] == RANGE_OFF) begin
          pkt_r[i].result <= '0;
        end else begin
          pkt_r[i].result <= samp_r[i];
        end
      end
    end
  end

  // range word assembly; a reopened window drops any partial word
  assign word_nxt  = {shift_r[RANGE_W-2:0], s2_r.config_serial_in};
  assign word_done = window_r && adv && (bit_cnt_r == POS_W'(LAST_BIT));

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      range_r   <= RANGE_RESET;
      shift_r   <= '0;
      bit_cnt_r <= '0;
    end else if (ce_i) begin
      if (open_evt) begin
        bit_cnt_r <= '0;
      end else if (window_r && adv) begin
        shift_r <= word_nxt;
        if (bit_cnt_r == POS_W'(LAST_BIT)) begin
          bit_cnt_r <= '0;
          if (word_nxt != '0) begin
            range_r <= word_nxt;
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + 5'h1;
        end
      end
    end
  end

  // echo at half the serial clock rate, parked low at the end of each conversion
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      echo_r <= 1'b0;
    end else if (ce_i) begin
      if (lane_load) begin
        echo_r <= 1'b0;
      end else if (adv) begin
        echo_r <= ~echo_r;
      end
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_lane
    ocsp_lane #(
      .LANE (g)
    ) u_lane (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .ce_i      (ce_i),
      .load_i    (lane_load),
      .adv_i     (adv),
      .pkts_i    (pkt_r),
      .bit_o     (lane_bits[g])
    );
  end

  assign result_lanes_o        = lane_bits;
  assign echo_clock_out_o      = echo_r;
  // released lines keep their level until a conversion end reloads them; the pad decides the wire
  assign result_lanes_oe_n_o   = {NUM_CH{s2_r.cs_n}};
  assign echo_clock_out_oe_n_o = s2_r.cs_n;
  assign busy_o                = busy_r;
  assign window_open_o         = window_r;
  assign range_o               = range_r;

  a_range_after_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    $fell(reset_i) |-> (range_r == RANGE_RESET) && !window_r)
    else $error("range register not all ones after reset");

  a_busy_on_convert: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (state_r == ST_IDLE && cnv_rise) |=> busy_r && !window_r)
    else $error("busy did not rise on convert");

  a_conv_min_len: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    $rose(busy_r) |-> busy_r[*2])
    else $error("conversion shorter than two cycles");

  a_load_echo_low: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    lane_load |=> !echo_r && $fell(busy_r) && window_r)
    else $error("echo not low or busy not falling after lane load");

  a_echo_toggles: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (adv && !lane_load) |=> (echo_r != $past(echo_r)))
    else $error("echo did not toggle on serial clock rise");

  a_word_written: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (word_done && !open_evt && word_nxt != '0) |=> (range_r == $past(word_nxt)))
    else $error("complete word not copied to range register");

  a_zero_word_kept: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (word_done && word_nxt == '0) |=> $stable(range_r))
    else $error("all-zero word changed the range register");

  a_partial_ignored: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (!word_done) |=> $stable(range_r))
    else $error("range register changed without a complete word");

  a_outside_window: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (!window_r) |=> $stable(range_r) && $stable(shift_r))
    else $error("config accepted outside the window");

  a_window_restart: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    open_evt |=> (bit_cnt_r == '0) && window_r)
    else $error("partial word survived a new window");

endmodule

`default_nettype wire

// File: test/ocsp_host.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the serial port: drives the pins, captures lanes on its own rising edges
module ocsp_host (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] lanes_i,
  input  wire logic [7:0] lanes_oe_n_i,
  output logic            sck_o,
  output logic            sdi_o,
  output logic            cs_n_o,
  output logic            cnv_o
);
  logic [7:0][63:0] cap;
  // a released lane reads back inverted, so a stale value never passes
  wire logic [7:0] seen = lanes_i ^ lanes_oe_n_i;

  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    cs_n_o = 1'b1;
    cnv_o = 1'b0;
    cap = '0;
  end

  task automatic half();
    repeat (4) @(negedge ref_clk_i);
  endtask

  // n bits of word, msb first; idle_hi leaves the clock high afterwards
  task automatic shift(input int n, input logic [63:0] word, input logic idle_hi);
    for (int k = 0; k < n; k++) begin
      sck_o = 1'b0;
      sdi_o = word[n-1-k];
      half();
      sck_o = 1'b1;
      for (int l = 0; l < 8; l++) cap[l] = {cap[l][62:0], seen[l]};
      half();
    end
    sck_o = idle_hi;
    sdi_o = 1'b0;
  endtask

  // a gap after the last clock keeps the shift clear of the conversion
  task automatic convert();
    repeat (2) @(negedge ref_clk_i);
    cnv_o = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    cnv_o = 1'b0;
  endtask
endmodule

`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ocsp_pkg::*;
  logic                        ref_clk_i = 1'b0;
  logic                        reset_i = 1'b1;
  logic                        ce = 1'b1;
  logic [7:0][63:0]            ddr;
  logic [NUM_CH-1:0][RES_W-1:0] samples;
  wire logic                   sck, config_serial_in, cs_n, convert_strobe;
  logic [7:0]                  lanes, oe_n;
  logic                        echo, echo_oe_n, busy, win;
  logic [RANGE_W-1:0]          rng;
  int                          mismatches = 0;
  int                          checked = 0;
  int                          run = 0;
  int                          last_len = 0;
  localparam logic [23:0]      W = 24'h29ca37;

  always #10 ref_clk_i = ~ref_clk_i;

  ocsp_port #(.INIT_CYCLES(20)) DUT (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce),
    .serial_clock_in_i(sck), .config_serial_in_i(config_serial_in), .chip_select_n_i(cs_n),
    .convert_strobe_i(convert_strobe), .sample_data_i(samples), .result_lanes_o(lanes),
    .result_lanes_oe_n_o(oe_n), .echo_clock_out_o(echo), .echo_clock_out_oe_n_o(echo_oe_n),
    .busy_o(busy), .window_open_o(win), .range_o(rng));

  ocsp_host host (
    .ref_clk_i(ref_clk_i), .lanes_i(lanes), .lanes_oe_n_i(oe_n),
    .sck_o(sck), .sdi_o(config_serial_in), .cs_n_o(cs_n), .cnv_o(convert_strobe));

  // double data rate capture on both echo edges, taken once the lanes settle
  always @(echo) begin
    #1;
    for (int l = 0; l < 8; l++) ddr[l] = {ddr[l][62:0], lanes[l]};
  end

  // length of the last busy pulse
  always @(negedge ref_clk_i) begin
    if (busy === 1'b1) run++;
    else if (run != 0) begin
      last_len = run;
      run = 0;
    end
  end

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic settle();
    repeat (5) @(negedge ref_clk_i);
  endtask

  task automatic set_cs(input logic v);
    @(negedge ref_clk_i);
    host.cs_n_o = v;
    settle();
  endtask

  function automatic logic [23:0] pkt(input int ch, input logic [23:0] r);
    logic [2:0] code;
    code = r[3*ch +: 3];
    return {(code == 3'h0) ? 18'h0 : samples[ch], 3'(ch), code};
  endfunction

  task automatic convert_run(input int exp_len, input logic [63:0] busy_word);
    last_len = 0;
    host.convert();
    if (busy_word !== 64'h0) host.shift(24, busy_word, 1'b0);
    for (int i = 0; !(last_len != 0 && win === 1'b1); i++) begin
      @(negedge ref_clk_i);
      if (i == 1000) begin
        mismatches++;
        $display("unexpected at %0t: no end of conversion", $time);
        conclude();
      end
    end
    chk(64'(last_len), 64'(exp_len), "busy length");
  endtask

  task automatic read_check(input logic [23:0] r);
    set_cs(1'b0);
    chk(64'({oe_n, echo}), 64'h0, "driven, echo low");
    host.cap = '0;
    ddr = '0;
    host.shift(1, 64'h0, 1'b0);
    settle();
    chk(64'(echo), 64'h1, "echo after one rise");
    host.shift(47, 64'h0, 1'b0);
    for (int n = 0; n < 8; n++) begin
      chk(64'(host.cap[n][47:0]), 64'({pkt(n, r), pkt((n + 1) % 8, r)}), "lane");
      chk(64'(ddr[n][47:1]), 64'(47'({pkt(n, r), pkt((n + 1) % 8, r)})), "ddr lane");
    end
    settle();
    chk(64'(rng), 64'(r), "range kept by zero words");
  endtask

  task automatic t_reset();
    chk(64'({rng, oe_n, echo_oe_n, win, busy}), {29'h0, 24'hffffff, 9'h1ff, 2'h0}, "reset");
    reset_i = 1'b0;
    repeat (18) @(negedge ref_clk_i);
    chk(64'(win), 64'h0, "window during init");
    repeat (4) @(negedge ref_clk_i);
    chk(64'(win), 64'h1, "window after init");
    $display("reset test done");
  endtask

  task automatic t_config();
    convert_run(216, 64'h0);
    read_check(24'hffffff);
    host.shift(24, 64'(W), 1'b0);
    settle();
    chk(64'(rng), 64'(W), "configured range");
    convert_run(189, 64'h0);
    read_check(W);
    $display("config test done");
  endtask

  task automatic t_partial();
    host.shift(23, 64'hffffff, 1'b0);
    settle();
    chk(64'(rng), 64'(W), "partial word");
    convert_run(189, 64'h0);
    chk(64'(echo), 64'h0, "echo forced low");
    ce = 1'b0;
    host.shift(1, 64'h1, 1'b0);
    ce = 1'b1;
    settle();
    chk(64'({echo, win, rng}), 64'({1'b0, 1'b1, W}), "frozen by clock enable");
    $display("partial test done");
  endtask

  task automatic t_multi();
    set_cs(1'b1);
    host.sck_o = 1'b1;
    set_cs(1'b0);
    host.shift(58, {6'h0, 24'h249249, 24'hb6db6d, 10'h3ff}, 1'b1);
    settle();
    chk(64'(rng), 64'hb6db6d, "last whole word");
    $display("multi test done");
  endtask

  task automatic t_refused();
    set_cs(1'b1);
    host.shift(24, 64'h249249, 1'b0);
    settle();
    chk(64'({rng, oe_n, echo_oe_n}), 64'({24'hb6db6d, 9'h1ff}), "chip select high");
    set_cs(1'b0);
    convert_run(216, 64'h249249);
    chk(64'(rng), 64'hb6db6d, "word while busy");
    host.cap = '0;
    host.shift(18, 64'h0, 1'b0);
    for (int n = 0; n < 8; n++)
      chk(64'(host.cap[n][17:0]), 64'(samples[n]), "short read");
    $display("refused test done");
  endtask

  initial begin
    for (int i = 0; i < NUM_CH; i++) samples[i] = 18'h2a5c3 + 18'(i * 'h0f0f);
    repeat (10) @(negedge ref_clk_i);
    t_reset();
    t_config();
    t_partial();
    t_multi();
    t_refused();
    conclude();
  end
endmodule

`default_nettype wire
